// [include/sar_conversion_control_regs.vh]
// Constants of the successive-approximation conversion sequencer.
// Assumes a 100 MHz system clock; included by the sequencer only.
`ifndef SAR_CONVERSION_CONTROL_REGS_VH
`define SAR_CONVERSION_CONTROL_REGS_VH

`define SAR_CLK_PERIOD_NS      10
`define SAR_RESULT_BITS        14
`define SAR_CODE_ZERO          14'h0000
`define SAR_CODE_MID           14'h2000
`define SAR_CODE_FULL          14'h3fff
// Shortest start-to-start interval at 250 kSPS, in ns
`define SAR_MIN_PERIOD_NS      4000
`define SAR_MIN_PERIOD_CYC     (`SAR_MIN_PERIOD_NS / `SAR_CLK_PERIOD_NS)
// Settle time between opening sample switches and moving the arrays
`define SAR_SWITCH_SETTLE_NS   20
`define SAR_SWITCH_SETTLE_CYC  ((`SAR_SWITCH_SETTLE_NS + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS)
// Internal conversion clock divider (system cycles per bit decision)
`define SAR_BIT_CYC            8

`endif

// [src/sar_conversion_control.v]
// Sequencer of a 14-bit charge-redistribution successive-approximation converter.
// Assumes the comparator and host pins are asynchronous to clk; serial clock from host.
// Functional notes
// [R01] A rising convert_start edge ends acquisition and starts a conversion.
// [R02] Sample switches ground array tops in acquisition; open first, then arrays go to ground.
// [R03] Search 14 binary-weighted elements MSB first, each kept or dropped by comparator.
// [R04] After the search return to acquisition, form the code, pulse busy done.
// [R05] Sequencing runs on the internal conversion timer, never on serial clock edges.
// [R06] Result is 14-bit straight binary, zero 0x0000, mid 0x2000, top 0x3fff.
// [R07] Inputs above the reference span saturate to all ones.
// [R08] Inputs below ground clamp to all zeros.
// [R09] The result belongs to the sample of the same start, with no pipeline latency.
// [R10] Starts up to 250 kSPS; the analog core powers down between conversions.
// [R11] The finished result shifts out serially on the external serial clock.
// [R12] The host starts the next conversion only after the current one completes.
`include "sar_conversion_control_regs.vh"

module sar_conversion_control #(
    parameter BITS       = `SAR_RESULT_BITS,
    parameter BIT_CYC    = `SAR_BIT_CYC,
    parameter SETTLE_CYC = `SAR_SWITCH_SETTLE_CYC
) (
    input  wire            clk,
    input  wire            rst_n,
    // Host and comparator pins, all asynchronous to clk
    input  wire            convert_start,
    input  wire            comp_out,
    input  wire            serial_clk,
    // Analog switch, array and power controls
    output reg             pos_sample_switch,
    output reg             neg_sample_switch,
    output reg             array_to_inputs,
    output reg  [BITS-1:0] dac_ctrl,
    output reg             analog_power_en,
    // Host indications and the finished code
    output reg             busy,
    output reg             done_pulse,
    output reg  [BITS-1:0] result,
    output reg             serial_result_out
);
    // Sequencer states, binary coded
    localparam [2:0] ST_ACQ    = 3'h0;
    localparam [2:0] ST_OPEN   = 3'h1;
    localparam [2:0] ST_ARRAY  = 3'h2;
    localparam [2:0] ST_SEARCH = 3'h3;
    localparam [2:0] ST_DONE   = 3'h4;

    reg            cnv_prev_q;
    reg            sck_prev_q;
    reg [2:0]      state_q;
    reg [7:0]      timer_q;
    reg [3:0]      bit_idx_q;
    reg [BITS-1:0] shift_q;

    // Pins packed so that one loop synchronises them all
    wire [2:0]      pin_raw = {serial_clk, comp_out, convert_start};
    wire [2:0]      pin_sync;
    wire            cnv_s = pin_sync[0];
    wire            cmp_s = pin_sync[1];
    wire            sck_s = pin_sync[2];
    wire            cnv_rise = cnv_s & ~cnv_prev_q;
    wire            sck_fall = ~sck_s & sck_prev_q;
    wire            timer_end = (timer_q <= 8'h01);
    wire [BITS-1:0] dac_next;

    genvar g;

    // Two-flop synchronisers, one per asynchronous pin; the first stage
    // feeds only the second, so no decision sees a metastable value
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_sync
            reg [1:0] stage_q;
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    stage_q <= 2'h0;
                end else begin
                    stage_q <= {stage_q[0], pin_raw[g]};
                end
            end
            assign pin_sync[g] = stage_q[1];
        end
    endgenerate

    // Edge detectors run on the synchronised levels only
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnv_prev_q <= 1'b0;
            sck_prev_q <= 1'b0;
        end else begin
            cnv_prev_q <= cnv_s;
            sck_prev_q <= sck_s;
        end
    end

    // Next trial code, one bit per element: the element under test is
    // dropped when the comparator says the trial overshoots, and the one
    // below becomes the next trial. Over-range keeps every element and
    // under-range drops every one, so the code saturates, never wraps.
    generate
        for (g = 0; g < BITS; g = g + 1) begin : g_trial
            assign dac_next[g] = ({28'h0, bit_idx_q} == g)     ? ~cmp_s :
                                 ({28'h0, bit_idx_q} == g + 1) ? 1'b1   :
                                 dac_ctrl[g];
        end
    endgenerate

    // Pacing timer: settle count after the switches open, then one
    // conversion-clock period per decision. A fixed divider keeps the
    // spacing exact, at the cost of a slower search than a self-timed one.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_q <= 8'h00;
        end else begin
            case (state_q)
                ST_ACQ: begin
                    timer_q <= SETTLE_CYC[7:0];
                end
                ST_OPEN, ST_SEARCH: begin
                    if (timer_end) begin
                        timer_q <= BIT_CYC[7:0]; // [R05]
                    end else begin
                        timer_q <= timer_q - 8'h01;
                    end
                end
                default: begin
                    timer_q <= 8'h00;
                end
            endcase
        end
    end

    // Element under test: the top element when the arrays move,
    // stepped down after each decision until the last one
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_idx_q <= 4'h0;
        end else if (state_q == ST_OPEN && timer_end) begin
            bit_idx_q <= BITS[3:0] - 4'h1; // [R03]
        end else if (state_q == ST_SEARCH && timer_end && bit_idx_q != 4'h0) begin
            bit_idx_q <= bit_idx_q - 4'h1;
        end
    end

    // Sequencer: acquisition, switch opening, bit search, completion.
    // The analog outputs are registers, so they never glitch.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q           <= ST_ACQ;
            pos_sample_switch <= 1'b1;
            neg_sample_switch <= 1'b1;
            array_to_inputs   <= 1'b1;
            dac_ctrl          <= `SAR_CODE_ZERO;
            analog_power_en   <= 1'b0;
            busy              <= 1'b0;
            done_pulse        <= 1'b0;
            result            <= `SAR_CODE_ZERO;
        end else begin
            done_pulse <= 1'b0;
            case (state_q)
                ST_ACQ: begin
                    // Starts while busy are ignored; the host must wait for done
                    if (cnv_rise) begin // [R01] [R12]
                        pos_sample_switch <= 1'b0; // [R02]
                        neg_sample_switch <= 1'b0; // [R02]
                        // Core is powered for one conversion only
                        analog_power_en   <= 1'b1; // [R10]
                        busy              <= 1'b1;
                        state_q           <= ST_OPEN;
                    end
                end
                ST_OPEN: begin
                    // Switches open a settle time before the arrays leave the inputs
                    if (timer_end) begin
                        array_to_inputs <= 1'b0; // [R02]
                        // Mid code: the top element is the first trial
                        dac_ctrl        <= `SAR_CODE_MID; // [R03]
                        state_q         <= ST_SEARCH;
                    end
                end
                ST_SEARCH: begin
                    // Internal timer paces each decision, serial clock not used
                    if (timer_end) begin // [R05]
                        dac_ctrl <= dac_next; // [R03] [R07] [R08]
                        if (bit_idx_q == 4'h0) begin
                            state_q <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    // Arrays back on the inputs, core off, code handed out
                    result            <= dac_ctrl; // [R06] [R09]
                    pos_sample_switch <= 1'b1; // [R04]
                    neg_sample_switch <= 1'b1;
                    array_to_inputs   <= 1'b1;
                    analog_power_en   <= 1'b0; // [R10]
                    busy              <= 1'b0; // [R04]
                    done_pulse        <= 1'b1; // [R04]
                    state_q           <= ST_ACQ;
                end
                default: begin
                    state_q <= ST_ACQ;
                end
            endcase
        end
    end

    // Serial readout: MSB loaded at completion, advanced on serial clock falls.
    // Limitation: falls past the last bit shift out zeros; the host counts bits.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_q           <= `SAR_CODE_ZERO;
            serial_result_out <= 1'b0;
        end else if (state_q == ST_DONE) begin
            shift_q           <= {dac_ctrl[BITS-2:0], 1'b0}; // [R11]
            serial_result_out <= dac_ctrl[BITS-1];
        end else if (sck_fall) begin
            shift_q           <= {shift_q[BITS-2:0], 1'b0}; // [R11]
            serial_result_out <= shift_q[BITS-1];
        end
    end
endmodule

// [test/sar_conversion_control_checker.sv]
// Port-level checks of the conversion sequencer.
// Assumes binding onto the sequencer with its BITS parameter.
module sar_conversion_control_checker #(parameter BITS = 14) (
    input wire logic            clk,
    input wire logic            rst_n,
    input wire logic            convert_start,
    input wire logic            comp_out,
    input wire logic            serial_clk,
    input wire logic            pos_sample_switch,
    input wire logic            neg_sample_switch,
    input wire logic            array_to_inputs,
    input wire logic [BITS-1:0] dac_ctrl,
    input wire logic            analog_power_en,
    input wire logic            busy,
    input wire logic            done_pulse,
    input wire logic [BITS-1:0] result,
    input wire logic            serial_result_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_start_opens_sw: assert property ($rose(busy) |-> !pos_sample_switch && !neg_sample_switch)
        else $error("switches closed at start");
    a_switch_then_array: assert property ($fell(array_to_inputs) |-> !pos_sample_switch)
        else $error("arrays moved before switches opened");
    a_msb_trial_first: assert property ($fell(array_to_inputs) |-> ##[0:1] dac_ctrl[BITS-1])
        else $error("search did not start at top element");
    a_done_ends_busy: assert property (done_pulse |-> !busy && $past(busy) && pos_sample_switch)
        else $error("completion without busy drop");
    a_done_one_cycle: assert property (done_pulse |=> !done_pulse)
        else $error("completion pulse too long");
    a_busy_bounded: assert property ($rose(busy) |-> ##[100:130] done_pulse)
        else $error("conversion did not finish in time");
    a_result_holds: assert property (!done_pulse |-> $stable(result))
        else $error("result changed without completion");
    a_idle_power_down: assert property (!busy |-> !analog_power_en)
        else $error("analog core powered while idle");
    a_msb_on_serial: assert property (done_pulse |-> serial_result_out == result[BITS-1])
        else $error("serial output not at top bit");
endmodule

// [test/sar_comparator_model.sv]
// Comparator and sampling array seen from the sequencer.
// Assumes vin is the input code; it is held when the arrays leave the inputs.
module sar_comparator_model (
    input wire logic        clk,
    input wire logic        array_to_inputs,
    input wire logic [13:0] dac_ctrl,
    input var int           vin,
    output logic            comp_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int held = 0;
    always @(posedge clk) if (array_to_inputs) held <= vin;
    assign comp_out = int'(dac_ctrl) > held;
endmodule

// [test/sar_conversion_control_test.sv]
// Self-checking bench of the conversion sequencer.
// Assumes the comparator model in its own file; the bench plays the host.
module sar_conversion_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, convert_start = 0, serial_clk = 1;
    logic pss, nss, ati, ape, busy, done_pulse, sro, comp_out;
    logic [13:0] dac_ctrl, result;
    logic [31:0] lfsr = 32'haceb;
    int vin = 0, n_mismatch = 0, samples_checked = 0, e;
    int codes[7] = '{0, 'h2000, 'h3fff, 'h44ff, -7, 1, 'h1fff};
    always #5 clk = ~clk;
    sar_conversion_control dut (.clk(clk), .rst_n(rst_n), .convert_start(convert_start),
        .comp_out(comp_out), .serial_clk(serial_clk), .pos_sample_switch(pss),
        .neg_sample_switch(nss), .array_to_inputs(ati), .dac_ctrl(dac_ctrl),
        .analog_power_en(ape), .busy(busy), .done_pulse(done_pulse), .result(result),
        .serial_result_out(sro));
    sar_comparator_model cmp (.clk(clk), .array_to_inputs(ati), .dac_ctrl(dac_ctrl),
        .vin(vin), .comp_out(comp_out));
    task check(input logic [13:0] got, input logic [13:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t bit got %b expected %b", $time, got, exp);
        end
    endtask
    task stop_test;
        if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Host side: start, optional retrigger while busy, then read serially
    task convert(input int v, input bit again);
        int n;
        vin = v;
        e = v < 0 ? 0 : (v > 16383 ? 16383 : v);
        @(negedge clk) convert_start = 1;
        repeat (20) @(negedge clk);
        if (again) begin
            vin = ~v;
            convert_start = 0;
            @(negedge clk) convert_start = 1;
        end
        for (n = 0; n < 300 && done_pulse !== 1'b1; n++) @(negedge clk);
        convert_start = 0;
        check_bit(done_pulse, 1'b1);
        check(result, e[13:0]);
        check_bit(sro, e[13]);
        for (n = 12; n >= 0; n--) begin
            serial_clk = 0;
            repeat (4) @(negedge clk);
            serial_clk = 1;
            repeat (4) @(negedge clk);
            check_bit(sro, e[n]);
        end
        repeat (300) @(negedge clk);
    endtask
    initial begin
        #200000;
        n_mismatch++;
        stop_test;
    end
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1;
        foreach (codes[i])
            convert(codes[i], i[0]);
        repeat (6) begin
            lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
            convert(int'(lfsr[13:0]), lfsr[14]);
        end
        stop_test;
    end
endmodule
bind sar_conversion_control sar_conversion_control_checker #(.BITS(BITS)) chk (.clk(clk),
    .rst_n(rst_n), .convert_start(convert_start), .comp_out(comp_out), .serial_clk(serial_clk),
    .pos_sample_switch(pos_sample_switch), .neg_sample_switch(neg_sample_switch),
    .array_to_inputs(array_to_inputs), .dac_ctrl(dac_ctrl), .analog_power_en(analog_power_en),
    .busy(busy), .done_pulse(done_pulse), .result(result), .serial_result_out(serial_result_out));
